// >>> rtl/pcrs_pkg.sv
// shared constants for the program counter and return stack block
package pcrs_pkg;

   // program counter and stack geometry
   localparam int          PC_W       = 21;
   localparam int          SP_W       = 5;
   localparam int          BYTE_W     = 8;
   localparam int          TOP_W      = 5;
   localparam int          WORD_W     = 16;
   localparam int          STACK_LAST = 31;

   // fixed program counter values
   localparam logic [20:0] RESET_VEC  = 21'h000000;
   localparam logic [20:0] IRQ_VEC_HI = 21'h000008;
   localparam logic [20:0] IRQ_VEC_LO = 21'h000018;
   localparam logic [20:0] PC_STEP    = 21'h000002;

   // stack pointer values
   localparam logic [4:0]  SP_EMPTY   = 5'h00;
   localparam logic [4:0]  SP_FULL    = 5'h1F;
   localparam logic [4:0]  SP_ONE     = 5'h01;

   // stack pointer register layout
   localparam int          FULL_BIT   = 7;
   localparam int          UNF_BIT    = 6;
   localparam int          SP_MSB     = 4;

   // byte lanes of the program counter
   localparam int          MID_LSB    = 8;
   localparam int          TOP_LSB    = 16;

   // wishbone register map, byte addresses
   localparam int          ADR_W      = 5;
   localparam int          DAT_W      = 32;
   localparam int          SEL_W      = 4;
   localparam logic [4:0]  ADR_PCL    = 5'h00;
   localparam logic [4:0]  ADR_LATMID = 5'h04;
   localparam logic [4:0]  ADR_LATTOP = 5'h08;
   localparam logic [4:0]  ADR_RETURN_STACK_POINTER = 5'h0C;
   localparam logic [4:0]  ADR_TOP_ENTRY_LOW_BYTE   = 5'h10;
   localparam logic [4:0]  ADR_TOP_ENTRY_HIGH_BYTE   = 5'h14;
   localparam logic [4:0]  ADR_TOP_ENTRY_UPPER_BYTE   = 5'h18;

   // reset values
   localparam logic [7:0]  BYTE_ZERO  = 8'h00;
   localparam logic [15:0] WORD_ZERO  = 16'h0000;
   localparam logic [31:0] DAT_ZERO   = 32'h00000000;

endpackage

// >>> rtl/pcrs_top.sv
// program counter, latches and 31-level return stack with wishbone registers
// Function
// - 21-bit byte-addressed program counter for fetch
// - fetch beyond implemented memory returns zero
// - vectors 0000h reset, 0008h and 0018h
// - three byte registers, only low byte accessible
// - top byte updated only via top latch
// - low byte write loads latches into counter
// - low byte read copies counter into latches
// - bit zero fixed except when a pop loads a software-written odd top entry, sequential step of two
// - call and jump load counter, no latches
// - calls and interrupts push, 31 levels
// - returns pop top entry into counter
// - calls and returns leave latches unchanged, except a fault reset clears them
// - 31 by 21 storage, 5-bit pointer
// - software reads/writes pointer and top entry
// - push increments pointer, then writes entry
// - pop reads entry, then decrements pointer
// - reset clears pointer, zero has no entry
// - full and underflow status flags
// - top entry registers follow the pointer
// - 31st push sets full, optional fault reset
// - without fault reset, pointer saturates at 31
// - empty pop returns zero, sets underflow
// - pointer register layout, flags software-cleared
module pcrs_top #(
   parameter logic [20:0] IMPL_BYTES = 21'h010000
) (
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [4:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   input  wire logic        CORE_ADV,
   input  wire logic        CORE_JUMP,
   input  wire logic        CORE_CALL,
   input  wire logic        CORE_RET,
   input  wire logic        CORE_IRQ_ACK,
   input  wire logic        CORE_IRQ_HIGH,
   input  wire logic [20:0] CORE_TARGET,
   input  wire logic        STACK_FAULT_RESET_EN,
   input  wire logic [15:0] FETCH_DATA_I,
   output logic      [20:0] FETCH_ADDR,
   output logic      [15:0] FETCH_WORD,
   output logic             STACK_FAULT_RESET,
   output logic             STACK_FULL,
   output logic             STACK_UNDERFLOW
);

   ////////////////////////////////////////////////////////////////////////
   // state
   logic [20:0] pc_ff;
   logic [20:0] nxt_pc;
   logic [7:0]  lat_mid_ff;
   logic [7:0]  nxt_lat_mid;
   logic [4:0]  lat_top_ff;
   logic [4:0]  nxt_lat_top;
   logic [4:0]  sp_ff;
   logic [4:0]  nxt_sp;
   logic        full_ff;
   logic        nxt_full;
   logic        unf_ff;
   logic        nxt_unf;
   logic        fault_ff;
   logic        nxt_fault;
   logic [15:0] fetch_ff;
   logic [15:0] nxt_fetch;
   logic        ack_ff;
   logic        nxt_ack;
   logic [31:0] dat_ff;
   logic [31:0] nxt_dat;

   // return stack storage, entry zero deliberately absent
   logic [20:0] stack_mem [1:pcrs_pkg::STACK_LAST];
   logic        mem_we;
   logic [4:0]  mem_wa;
   logic [20:0] mem_wd;

   logic        core_busy;
   logic        bus_go;
   logic        bus_wr;
   logic        do_push;
   logic [20:0] top_stack_entry;
   logic [20:0] push_val;
   logic [20:0] push_tgt;
   logic [4:0]  sp_inc;
   logic [7:0]  rd_byte;

   ////////////////////////////////////////////////////////////////////////
   // shared decode
   assign core_busy = CORE_ADV | CORE_JUMP | CORE_CALL | CORE_RET | CORE_IRQ_ACK;
   // bus waits while the core acts, so the two never collide on one edge
   assign bus_go    = WB_CYC_I & WB_STB_I & ~ack_ff & ~core_busy;
   assign bus_wr    = bus_go & WB_WE_I & WB_SEL_I[0];
   assign do_push   = CORE_CALL | CORE_IRQ_ACK;
   assign sp_inc    = 5'(sp_ff + pcrs_pkg::SP_ONE);
   assign top_stack_entry       = (sp_ff == pcrs_pkg::SP_EMPTY) ? pcrs_pkg::RESET_VEC : stack_mem[sp_ff];
   assign push_tgt  = CORE_IRQ_ACK ? (CORE_IRQ_HIGH ? pcrs_pkg::IRQ_VEC_HI : pcrs_pkg::IRQ_VEC_LO)
                                   : {CORE_TARGET[20:1], 1'b0};
   // calls push the address past the call, interrupts the next fetch
   assign push_val  = CORE_IRQ_ACK ? pc_ff : 21'(pc_ff + pcrs_pkg::PC_STEP);

   ////////////////////////////////////////////////////////////////////////
   // register read mux
   always_comb begin
      rd_byte = pcrs_pkg::BYTE_ZERO;
      unique case (WB_ADR_I)
         pcrs_pkg::ADR_PCL:    rd_byte = pc_ff[7:0];
         pcrs_pkg::ADR_LATMID: rd_byte = lat_mid_ff;
         pcrs_pkg::ADR_LATTOP: rd_byte = {3'h0, lat_top_ff};
         // flag and pointer layout, bit five reads zero
         pcrs_pkg::ADR_RETURN_STACK_POINTER: rd_byte = {full_ff, unf_ff, 1'b0, sp_ff};
         pcrs_pkg::ADR_TOP_ENTRY_LOW_BYTE:   rd_byte = top_stack_entry[7:0];
         pcrs_pkg::ADR_TOP_ENTRY_HIGH_BYTE:   rd_byte = top_stack_entry[15:8];
         pcrs_pkg::ADR_TOP_ENTRY_UPPER_BYTE:   rd_byte = {3'h0, top_stack_entry[20:16]};
         default:              rd_byte = pcrs_pkg::BYTE_ZERO;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // next state of counter, latches, pointer and flags
   always_comb begin
      nxt_pc      = pc_ff;
      nxt_lat_mid = lat_mid_ff;
      nxt_lat_top = lat_top_ff;
      nxt_sp      = sp_ff;
      nxt_full    = full_ff;
      nxt_unf     = unf_ff;
      nxt_fault   = 1'b0;
      mem_we      = 1'b0;
      mem_wa      = sp_inc;
      mem_wd      = push_val;
      if (do_push) begin
         // branch target taken straight, latches untouched
         nxt_pc = push_tgt;
         if (sp_ff == pcrs_pkg::SP_FULL) begin
            nxt_full = 1'b1;
         end else begin
            nxt_sp = sp_inc;
            mem_we = 1'b1;
            if (sp_inc == pcrs_pkg::SP_FULL) begin
               // full flag on the last level
               nxt_full = 1'b1;
               if (STACK_FAULT_RESET_EN) begin
                  // fault reset keeps the flag set
                  nxt_sp      = pcrs_pkg::SP_EMPTY;
                  nxt_pc      = pcrs_pkg::RESET_VEC;
                  nxt_lat_mid = pcrs_pkg::BYTE_ZERO;
                  nxt_lat_top = 5'h00;
                  nxt_fault   = 1'b1;
               end
            end
         end
      end else if (CORE_RET) begin
         if (sp_ff == pcrs_pkg::SP_EMPTY) begin
            nxt_pc  = pcrs_pkg::RESET_VEC;
            nxt_unf = 1'b1;
            if (STACK_FAULT_RESET_EN) begin
               nxt_lat_mid = pcrs_pkg::BYTE_ZERO;
               nxt_lat_top = 5'h00;
               nxt_fault   = 1'b1;
            end
         end else begin
            // entry to counter, then pointer down
            nxt_pc = top_stack_entry;
            nxt_sp = 5'(sp_ff - pcrs_pkg::SP_ONE);
         end
      end else if (CORE_JUMP) begin
         nxt_pc = {CORE_TARGET[20:1], 1'b0};
      end else if (CORE_ADV) begin
         nxt_pc = 21'(pc_ff + pcrs_pkg::PC_STEP);
      end else if (bus_go) begin
         if (!WB_WE_I && WB_ADR_I == pcrs_pkg::ADR_PCL) begin
            // low byte read snapshots the upper bytes
            nxt_lat_mid = pc_ff[15:8];
            nxt_lat_top = pc_ff[20:16];
         end
         if (bus_wr) begin
            unique case (WB_ADR_I)
               pcrs_pkg::ADR_PCL: begin
                  // low byte write carries latches in
                  nxt_pc = {lat_top_ff, lat_mid_ff, WB_DAT_I[7:1], 1'b0};
               end
               pcrs_pkg::ADR_LATMID: nxt_lat_mid = WB_DAT_I[7:0];
               pcrs_pkg::ADR_LATTOP: nxt_lat_top = WB_DAT_I[4:0];
               pcrs_pkg::ADR_RETURN_STACK_POINTER: begin
                  // flags clear on zero only, pointer written
                  nxt_full = full_ff & WB_DAT_I[pcrs_pkg::FULL_BIT];
                  nxt_unf  = unf_ff & WB_DAT_I[pcrs_pkg::UNF_BIT];
                  nxt_sp   = WB_DAT_I[pcrs_pkg::SP_MSB:0];
               end
               pcrs_pkg::ADR_TOP_ENTRY_LOW_BYTE: begin
                  // top entry byte writes, ignored when empty
                  mem_we = (sp_ff != pcrs_pkg::SP_EMPTY);
                  mem_wa = sp_ff;
                  mem_wd = {top_stack_entry[20:8], WB_DAT_I[7:0]};
               end
               pcrs_pkg::ADR_TOP_ENTRY_HIGH_BYTE: begin
                  mem_we = (sp_ff != pcrs_pkg::SP_EMPTY);
                  mem_wa = sp_ff;
                  mem_wd = {top_stack_entry[20:16], WB_DAT_I[7:0], top_stack_entry[7:0]};
               end
               pcrs_pkg::ADR_TOP_ENTRY_UPPER_BYTE: begin
                  mem_we = (sp_ff != pcrs_pkg::SP_EMPTY);
                  mem_wa = sp_ff;
                  mem_wd = {WB_DAT_I[4:0], top_stack_entry[15:0]};
               end
               default: begin
                  nxt_pc = pc_ff;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus answer and fetch word next values
   always_comb begin
      nxt_ack = bus_go;
      nxt_dat = bus_go ? {24'h000000, rd_byte} : dat_ff;
      // unimplemented space reads as all zeros
      nxt_fetch = (pc_ff < IMPL_BYTES) ? FETCH_DATA_I : pcrs_pkg::WORD_ZERO;
   end

   ////////////////////////////////////////////////////////////////////////
   // control registers; the reset is treated as power-on
   // pointer empty after every reset
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pc_ff      <= pcrs_pkg::RESET_VEC;
         lat_mid_ff <= pcrs_pkg::BYTE_ZERO;
         lat_top_ff <= 5'h00;
         sp_ff      <= pcrs_pkg::SP_EMPTY;
         full_ff    <= 1'b0;
         unf_ff     <= 1'b0;
         fault_ff   <= 1'b0;
         fetch_ff   <= pcrs_pkg::WORD_ZERO;
         ack_ff     <= 1'b0;
         dat_ff     <= pcrs_pkg::DAT_ZERO;
      end else begin
         pc_ff      <= nxt_pc;
         lat_mid_ff <= nxt_lat_mid;
         lat_top_ff <= nxt_lat_top;
         sp_ff      <= nxt_sp;
         full_ff    <= nxt_full;
         unf_ff     <= nxt_unf;
         fault_ff   <= nxt_fault;
         fetch_ff   <= nxt_fetch;
         ack_ff     <= nxt_ack;
         dat_ff     <= nxt_dat;
      end
   end

   // storage has no reset; contents valid once pushed
   always_ff @(posedge CLK) begin
      if (mem_we) begin
         stack_mem[mem_wa] <= mem_wd;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs straight from flops
   // full 21-bit fetch address
   assign FETCH_ADDR        = pc_ff;
   assign FETCH_WORD        = fetch_ff;
   assign WB_DAT_O          = dat_ff;
   assign WB_ACK_O          = ack_ff;
   assign STACK_FAULT_RESET = fault_ff;
   assign STACK_FULL        = full_ff;
   assign STACK_UNDERFLOW   = unf_ff;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   sequence s_pcl_write;
      bus_wr && WB_ADR_I == pcrs_pkg::ADR_PCL;
   endsequence

   sequence s_pcl_read;
      bus_go && !WB_WE_I && WB_ADR_I == pcrs_pkg::ADR_PCL;
   endsequence

   sequence s_plain_push;
      do_push && sp_ff < 5'h1E;
   endsequence

   // pop with a real entry behind the pointer
   sequence s_plain_pop;
      CORE_RET && !do_push && sp_ff != pcrs_pkg::SP_EMPTY;
   endsequence

   // push that fills the last free level
   sequence s_last_push;
      do_push && sp_ff == 5'(pcrs_pkg::SP_FULL - pcrs_pkg::SP_ONE);
   endsequence

   a_pc_word_align: assert property (pc_ff[0] == 1'b0)
      else $error("program counter lost word alignment");

   a_adv_by_two: assert property (CORE_ADV && !CORE_JUMP && !do_push && !CORE_RET
                                  |=> pc_ff == 21'($past(pc_ff) + pcrs_pkg::PC_STEP))
      else $error("sequential step was not two");

   a_irq_vector: assert property (CORE_IRQ_ACK && sp_ff < 5'h1E
                                  |=> pc_ff == ($past(CORE_IRQ_HIGH) ? 21'h000008 : 21'h000018))
      else $error("interrupt vector wrong");

   a_push_incr: assert property (s_plain_push |=> sp_ff == 5'($past(sp_ff) + 5'h01)
                                 && top_stack_entry == $past(push_val))
      else $error("push did not step pointer and store");

   a_sat_hold: assert property (do_push && sp_ff == 5'h1F |=> sp_ff == 5'h1F && full_ff)
      else $error("saturated stack moved");

   a_empty_pop: assert property (CORE_RET && !do_push && sp_ff == 5'h00
                                 |=> pc_ff == 21'h000000 && unf_ff && sp_ff == 5'h00)
      else $error("empty pop handled wrongly");

   a_fault_reset: assert property (fault_ff |-> sp_ff == 5'h00 && pc_ff == 21'h000000 && (full_ff || unf_ff)
                                   ##1 !fault_ff)
      else $error("fault reset state wrong");

   a_pcl_write_lat: assert property (s_pcl_write |=> pc_ff[20:8] == {$past(lat_top_ff), $past(lat_mid_ff)})
      else $error("low byte write did not carry latches");

   a_pcl_read_lat: assert property (s_pcl_read |=> {lat_top_ff, lat_mid_ff} == $past(pc_ff[20:8]))
      else $error("low byte read did not copy upper bytes");

   a_call_keep_lat: assert property (do_push && !fault_ff ##0 !nxt_fault
                                     |=> $stable(lat_mid_ff) && $stable(lat_top_ff))
      else $error("call disturbed latches");

   a_fetch_zero: assert property (pc_ff >= IMPL_BYTES |=> fetch_ff == 16'h0000)
      else $error("unimplemented fetch not zero");

   a_ack_pulse: assert property (ack_ff |=> !ack_ff)
      else $error("ack held more than one cycle");

   // pop loads the old top, then the pointer steps down
   a_pop_decr: assert property (s_plain_pop |=> pc_ff == $past(top_stack_entry)
                                && sp_ff == 5'($past(sp_ff) - pcrs_pkg::SP_ONE))
      else $error("pop did not load entry and step pointer");

   a_pop_keep_lat: assert property (s_plain_pop |=> $stable(lat_mid_ff) && $stable(lat_top_ff))
      else $error("return disturbed latches");

   // jump bypasses the latches entirely
   a_jump_load: assert property (CORE_JUMP && !do_push && !CORE_RET
                                 |=> pc_ff == ($past(CORE_TARGET) & 21'h1FFFFE)
                                 && $stable(lat_mid_ff) && $stable(lat_top_ff))
      else $error("jump target or latches wrong");

   // flags only fall through a pointer register write
   a_full_sticky: assert property (full_ff && !(bus_wr && WB_ADR_I == pcrs_pkg::ADR_RETURN_STACK_POINTER)
                                   |=> full_ff)
      else $error("full flag cleared by hardware");

   a_unf_sticky: assert property (unf_ff && !(bus_wr && WB_ADR_I == pcrs_pkg::ADR_RETURN_STACK_POINTER)
                                  |=> unf_ff)
      else $error("underflow flag cleared by hardware");

   // last level: full in both modes, pointer per fault reset choice
   a_last_push: assert property (s_last_push |=> full_ff
                                 && (fault_ff ? sp_ff == pcrs_pkg::SP_EMPTY : sp_ff == pcrs_pkg::SP_FULL))
      else $error("last level push handled wrongly");

endmodule

// >>> dv/pcrs_core_model.sv
// core decode stand-in: one-cycle pc commands and a program memory image
module pcrs_core_model (
   input  wire logic        clk,
   input  wire logic [20:0] fetch_addr,
   output logic      [5:0]  cmd,
   output logic      [20:0] target,
   output logic      [15:0] fetch_data
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cmd = 6'h00;
      target = 21'h000000;
   end

   // memory word differs per address, so a zeroed fetch cannot pass by luck
   assign fetch_data = fetch_addr[15:0] ^ 16'hC3A5;

   ////////////////////////////////////////////////////////////////////////
   // one command per call: bit0 step, 1 jump, 2 call, 3 return, 4 irq, 5 irq high
   // no irq during stack access
   task automatic issue(input logic [5:0] c, input logic [20:0] tgt);
      @(posedge clk);
      cmd <= c;
      target <= tgt;
      @(posedge clk);
      cmd <= 6'h00;
      target <= ~tgt; // released target never repeats the old value
      #1;
   endtask
endmodule

// >>> dv/pcrs_top_test.sv
// self-checking bench for the program counter and return stack block
module pcrs_top_test;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [20:0] IMPL = 21'h000100;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cs = 1'b0;
   logic        we = 1'b0;
   logic [4:0]  adr = 5'h00;
   logic [31:0] wdat = 32'h00000000;
   logic        fault_en = 1'b0;
   logic [31:0] rdat;
   logic [31:0] dat_o;
   logic        ack;
   logic [5:0]  cmd;
   logic [20:0] target;
   logic [15:0] fdata;
   logic [20:0] pc;
   logic [15:0] fword;
   logic        fault_rst;
   logic        full;
   logic        unf;
   int          fails = 0;
   int          cmp_count = 0;
   int          cycles = 0;

   pcrs_top #(.IMPL_BYTES(IMPL)) i_dut (.CLK(clk), .RST_N(rst_n), .WB_CYC_I(cs), .WB_STB_I(cs),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
      .CORE_ADV(cmd[0]), .CORE_JUMP(cmd[1]), .CORE_CALL(cmd[2]), .CORE_RET(cmd[3]), .CORE_IRQ_ACK(cmd[4]),
      .CORE_IRQ_HIGH(cmd[5]), .CORE_TARGET(target), .STACK_FAULT_RESET_EN(fault_en), .FETCH_DATA_I(fdata),
      .FETCH_ADDR(pc), .FETCH_WORD(fword), .STACK_FAULT_RESET(fault_rst), .STACK_FULL(full),
      .STACK_UNDERFLOW(unf));

   pcrs_core_model i_core (.clk(clk), .fetch_addr(pc), .cmd(cmd), .target(target), .fetch_data(fdata));

   // clock, and a ceiling well above the few hundred cycles the tests need
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // classic single cycle; read data taken at the edge that sees ack
   task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cs <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h000000, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 40);
      rdat = dat_o;
      if (n >= 40) fails++;
      cs <= 1'b0;
   endtask

   // one core command, then the new pc
   task automatic core(input logic [5:0] c, input logic [20:0] tgt, input logic [20:0] exp);
      i_core.issue(c, tgt);
      chk("pc", 32'(pc), 32'(exp));
   endtask

   // pointer register and the three top entry bytes
   task automatic stack_is(input logic [7:0] sp, input logic [20:0] top_stack_entry);
      wb(1'b0, pcrs_pkg::ADR_RETURN_STACK_POINTER, 8'h00);
      chk("stack ptr", rdat, 32'(sp));
      wb(1'b0, pcrs_pkg::ADR_TOP_ENTRY_LOW_BYTE, 8'h00);
      chk("tos low", rdat, 32'(top_stack_entry[7:0]));
      wb(1'b0, pcrs_pkg::ADR_TOP_ENTRY_HIGH_BYTE, 8'h00);
      chk("tos high", rdat, 32'(top_stack_entry[15:8]));
      wb(1'b0, pcrs_pkg::ADR_TOP_ENTRY_UPPER_BYTE, 8'h00);
      chk("tos upper", rdat, 32'(top_stack_entry[20:16]));
   endtask

   task automatic latches_are(input logic [7:0] mid, input logic [7:0] top);
      wb(1'b0, pcrs_pkg::ADR_LATMID, 8'h00);
      chk("mid latch", rdat, 32'(mid));
      wb(1'b0, pcrs_pkg::ADR_LATTOP, 8'h00);
      chk("top latch", rdat, 32'(top));
   endtask

   ////////////////////////////////////////////////////////////////////////
   // reset state, unmapped read, fetch stepping and the memory limit
   task automatic t_reset_fetch();
      logic [20:0] tg [3] = '{IMPL - 21'h2, IMPL, 21'h1FFFFF};
      chk("pc", 32'(pc), 32'h0);
      stack_is(8'h00, 21'h0);
      latches_are(8'h00, 8'h00);
      wb(1'b0, 5'h1C, 8'h00);
      chk("unmapped", rdat, 32'h0);
      core(6'h01, 21'h0, 21'h2);
      core(6'h01, 21'h0, 21'h4);
      @(posedge clk);
      #1;
      chk("word", 32'(fword), 32'(16'h0004 ^ 16'hC3A5));
      for (int i = 0; i < 3; i++) begin
         core(6'h02, tg[i], tg[i] & 21'h1FFFFE);
         @(posedge clk);
         #1;
         chk("word", 32'(fword), (i == 0) ? 32'(16'h00FE ^ 16'hC3A5) : 32'h0);
      end
   endtask

   // latch transfers on low byte write and read
   task automatic t_latch();
      wb(1'b1, pcrs_pkg::ADR_LATMID, 8'h12);
      wb(1'b1, pcrs_pkg::ADR_LATTOP, 8'h1F);
      chk("pc", 32'(pc), 32'h1FFFFE);
      wb(1'b1, pcrs_pkg::ADR_PCL, 8'h35);
      chk("pc", 32'(pc), 32'h1F1234);
      core(6'h02, 21'h0ABCD0, 21'h0ABCD0);
      latches_are(8'h12, 8'h1F);
      wb(1'b0, pcrs_pkg::ADR_PCL, 8'h00);
      chk("pc low", rdat, 32'hD0);
      latches_are(8'hBC, 8'h0A);
   endtask

   // nested call and interrupts, unwinding, then an empty pop
   task automatic t_nest();
      core(6'h02, 21'h000200, 21'h000200);
      core(6'h04, 21'h000400, 21'h000400);
      stack_is(8'h01, 21'h000202);
      core(6'h30, 21'h0, 21'h000008);
      stack_is(8'h02, 21'h000400);
      core(6'h10, 21'h0, 21'h000018);
      stack_is(8'h03, 21'h000008);
      core(6'h08, 21'h0, 21'h000008);
      core(6'h08, 21'h0, 21'h000400);
      core(6'h08, 21'h0, 21'h000202);
      latches_are(8'hBC, 8'h0A);
      core(6'h08, 21'h0, 21'h000000);
      chk("underflow", 32'(unf), 32'h1);
      stack_is(8'h40, 21'h0);
      wb(1'b1, pcrs_pkg::ADR_RETURN_STACK_POINTER, 8'h00);
      stack_is(8'h00, 21'h0);
   endtask

   // saturation without fault reset, then the fault reset path
   task automatic t_full();
      for (int i = 1; i <= 31; i++) begin
         core(6'h04, 21'(4 * i), 21'(4 * i));
      end
      chk("full", 32'(full), 32'h1);
      stack_is(8'h9F, 21'h00007A);
      core(6'h04, 21'h000300, 21'h000300);
      stack_is(8'h9F, 21'h00007A);
      wb(1'b1, pcrs_pkg::ADR_RETURN_STACK_POINTER, 8'h1E);
      fault_en <= 1'b1;
      core(6'h04, 21'h000500, 21'h000000);
      chk("fault", 32'(fault_rst), 32'h1);
      stack_is(8'h80, 21'h0);
      latches_are(8'h00, 8'h00);
   endtask

   // software-built entry popped, then an empty pop under fault reset
   task automatic t_soft_entry();
      wb(1'b1, pcrs_pkg::ADR_RETURN_STACK_POINTER, 8'h01);
      wb(1'b1, pcrs_pkg::ADR_TOP_ENTRY_LOW_BYTE, 8'h46);
      wb(1'b1, pcrs_pkg::ADR_TOP_ENTRY_HIGH_BYTE, 8'h23);
      wb(1'b1, pcrs_pkg::ADR_TOP_ENTRY_UPPER_BYTE, 8'h01);
      stack_is(8'h01, 21'h012346);
      core(6'h08, 21'h0, 21'h012346);
      core(6'h08, 21'h0, 21'h000000);
      chk("fault", 32'(fault_rst), 32'h1);
      stack_is(8'h40, 21'h0);
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // reset for two cycles, then each scenario in turn
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      t_reset_fetch();
      t_latch();
      t_nest();
      t_full();
      t_soft_entry();
      complete_run();
   end
endmodule
